// *** core/board_interrupt_priority_unit.sv ***
// Priority interrupt unit with routing matrix, fail-safe timer, power-fail and memory-protect logic
//
// Behaviour
// R1 - Nine levels, top one nonmaskable straight out
// R2 - Unit prioritises and vectors eight lower levels
// R3 - Nested mode: line 0 highest, 7 lowest
// R4 - Rotating: serviced level becomes lowest priority
// R5 - Specific mode: software names lowest, rest follow
// R6 - Polled mode: encoded status readable by software
// R7 - Mode and priorities changeable anytime, no reset
// R8 - One byte write masks any level combination
// R9 - Interrupt only for qualifying unmasked request
// R10 - Requests from on-board resources and bus
// R11 - Slave units cascade, supplying own vectors
// R12 - Twenty-four request sources accepted
// R13 - Matrix routes any source to level/NMI
// R14 - Bus fail-safe timer requests after 6 ms
// R15 - Low memory protect blocks RAM access
// R16 - Mains-low warning raises power-fail request
// R17 - Eight bus request lines, cascadable to 64
// R18 - Parallel port gives three requests
// R19 - Serial port gives two requests
// R20 - Timer 0 and 1 outputs are sources
// R21 - 120 Hz line clock is a source
// R22 - Coprocessor error is one source
// R23 - Masked request stays pending, no interrupt
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module board_interrupt_priority_unit #(
  parameter int FAILSAFE_CYCLES = board_irq_pkg::FAILSAFE_CYCLES_DEF
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request sources from pins
  input wire board_irq_pkg::irq_src_s irqSrc,
  // System bus command watch for the fail-safe timer
  input wire logic busCmdActive,
  input wire logic busCmdAck,
  // Power supply and memory protect
  input wire logic mainsLowWarning,
  input wire logic memProtect_n,
  // Cascaded slave unit vector
  input wire logic [7:0] slaveVector,
  // Processor side
  output logic cpuIrq,
  output logic cpuNmi,
  output logic [2:0] cascadeSel,
  output logic ramBlock
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  localparam int SYNC_W = board_irq_pkg::SOURCES + 12;

  logic [SYNC_W-1:0] syncA_r;
  logic [SYNC_W-1:0] syncB_r;
  logic [SYNC_W-1:0] asyncIn;
  localparam logic [SYNC_W-1:0] SYNC_RST = 36'h008000000; // Protect pin idles high, no false block

  assign asyncIn = {slaveVector, memProtect_n, mainsLowWarning, busCmdAck, busCmdActive,
                    irqSrc[21:20], 2'b00, irqSrc[19:0]}; // Slots 21:20 kept for internal requests

  // Two flops per pin, first stage read only by the second
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : gSync
      always_ff @(posedge clk) begin
        if (rst) begin
          syncA_r[g] <= SYNC_RST[g];
          syncB_r[g] <= SYNC_RST[g];
        end else if (ce) begin
          syncA_r[g] <= asyncIn[g];
          syncB_r[g] <= syncA_r[g];
        end
      end
    end
  endgenerate

  logic [23:0] srcSync;
  logic cmdActS;
  logic cmdAckS;
  logic mainsLowS;
  logic protS_n;
  logic [7:0] slaveVecS;

  assign srcSync = syncB_r[23:0]; // [R10] [R12] [R17] [R18] [R19] [R20] [R21] [R22]
  assign cmdActS = syncB_r[24];
  assign cmdAckS = syncB_r[25];
  assign mainsLowS = syncB_r[26];
  assign protS_n = syncB_r[27];
  assign slaveVecS = syncB_r[35:28];

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  board_irq_pkg::ctrl_s ctrl_r;
  logic [7:0] mask_r;
  logic [4:0] vbase_r;
  logic [95:0] route_r;
  logic [7:0] casc_r;
  logic [2:0] rotLow_r;
  logic [7:0] isr_r;
  logic tmoFlag_r;
  logic pfFlag_r;
  logic mainsLowD_r;
  logic [board_irq_pkg::TMO_CNT_W-1:0] tmoCnt_r;

  // APB access decode: act in the first access cycle, answer next cycle
  logic acc;
  logic wrAcc;
  logic rdAcc;
  logic mapped;

  assign acc = psel && penable && !pready;
  assign wrAcc = acc && pwrite;
  assign rdAcc = acc && !pwrite;

  always_comb begin
    case (paddr)
      board_irq_pkg::CTRL_OFS, board_irq_pkg::MASK_OFS, board_irq_pkg::PEND_OFS,
      board_irq_pkg::POLL_OFS, board_irq_pkg::VECT_OFS, board_irq_pkg::EOI_OFS,
      board_irq_pkg::VBASE_OFS, board_irq_pkg::ROUTE0_OFS, board_irq_pkg::ROUTE1_OFS,
      board_irq_pkg::ROUTE2_OFS, board_irq_pkg::STAT_OFS, board_irq_pkg::CASC_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing matrix and priority resolution

  logic [23:0] srcAll;
  logic [7:0] levelReq;
  logic nmiReq;

  // Internal requests replace the timeout and power-fail source slots
  always_comb begin
    srcAll = srcSync;
    srcAll[board_irq_pkg::SRC_TMO] = tmoFlag_r; // [R14]
    srcAll[board_irq_pkg::SRC_PFAIL] = pfFlag_r; // [R16]
  end

  // Each source ORs onto the level or NMI its route code names
  always_comb begin
    levelReq = 8'h00;
    nmiReq = 1'b0;
    for (int s = 0; s < board_irq_pkg::SOURCES; s++) begin
      if (srcAll[s] && route_r[s*4+3] == 1'b0) begin
        levelReq[route_r[s*4 +: 3]] = 1'b1; // [R13]
      end
      if (srcAll[s] && route_r[s*4 +: 4] == board_irq_pkg::ROUTE_NMI) begin
        nmiReq = 1'b1; // [R13] [R1]
      end
    end
  end

  // First set bit of v walking upward from start, with a valid flag on top
  function automatic logic [3:0] pickFirst(input logic [7:0] v, input logic [2:0] start);
    logic [3:0] res;
    logic [2:0] k;
    res = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      k = start + 3'(i);
      if (v[k]) begin
        res = {1'b1, k};
      end
    end
    return res;
  endfunction : pickFirst

  logic [2:0] effLow;
  logic [2:0] startLvl;
  logic [3:0] reqPick;
  logic [3:0] isrPick;
  logic [2:0] reqRank;
  logic [2:0] isrRank;
  logic qualify;

  // Lowest level per mode; changes apply immediately
  always_comb begin
    case (ctrl_r.mode)
      board_irq_pkg::MODE_NESTED: effLow = 3'h7; // [R3]
      board_irq_pkg::MODE_ROTATE: effLow = rotLow_r; // [R4]
      board_irq_pkg::MODE_SPECIFIC: effLow = ctrl_r.lowest; // [R5] [R7]
      default: effLow = 3'h7;
    endcase
  end

  assign startLvl = effLow + 3'h1;
  assign reqPick = pickFirst(levelReq & ~mask_r, startLvl); // [R8] [R23]
  assign isrPick = pickFirst(isr_r, startLvl);
  assign reqRank = reqPick[2:0] - startLvl;
  assign isrRank = isrPick[2:0] - startLvl;

  // Unmasked request that outranks everything in service
  assign qualify = reqPick[3] && (!isrPick[3] || reqRank < isrRank); // [R9] [R2]

  ////////////////////////////////////////////////////////////////////////////
  // Processor outputs

  always_ff @(posedge clk) begin
    if (rst) begin
      cpuIrq <= 1'b0;
      cpuNmi <= 1'b0;
    end else if (ce) begin
      cpuIrq <= qualify && (ctrl_r.mode != board_irq_pkg::MODE_POLLED); // [R9] [R6]
      cpuNmi <= nmiReq; // [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r.mode <= board_irq_pkg::MODE_NESTED;
      ctrl_r.lowest <= board_irq_pkg::LOW_RST;
      mask_r <= board_irq_pkg::MASK_RST;
      vbase_r <= board_irq_pkg::VBASE_RST;
      casc_r <= board_irq_pkg::CASC_RST;
      route_r <= {3{board_irq_pkg::ROUTE_RST}};
    end else if (ce && wrAcc) begin
      case (paddr)
        board_irq_pkg::CTRL_OFS: begin
          ctrl_r.mode <= board_irq_pkg::pri_mode_e'(pwdata[board_irq_pkg::CTRL_MODE_LSB +: 2]); // [R7]
          ctrl_r.lowest <= pwdata[board_irq_pkg::CTRL_LOW_LSB +: 3]; // [R5]
        end
        board_irq_pkg::MASK_OFS: mask_r <= pwdata[7:0]; // [R8]
        board_irq_pkg::VBASE_OFS: vbase_r <= pwdata[board_irq_pkg::VBASE_LSB +: 5];
        board_irq_pkg::CASC_OFS: casc_r <= pwdata[7:0]; // [R11]
        board_irq_pkg::ROUTE0_OFS: route_r[31:0] <= pwdata; // [R13]
        board_irq_pkg::ROUTE1_OFS: route_r[63:32] <= pwdata; // [R13]
        board_irq_pkg::ROUTE2_OFS: route_r[95:64] <= pwdata; // [R13]
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // In-service tracking, acknowledge and end of interrupt

  logic ackRead;
  logic eoiWrite;

  // Vector read acknowledges outside polled mode; poll read acknowledges in polled mode only
  assign ackRead = rdAcc && reqPick[3] && ((paddr == board_irq_pkg::VECT_OFS &&
                   ctrl_r.mode != board_irq_pkg::MODE_POLLED) ||
                   (paddr == board_irq_pkg::POLL_OFS && ctrl_r.mode == board_irq_pkg::MODE_POLLED));
  assign eoiWrite = wrAcc && paddr == board_irq_pkg::EOI_OFS;

  always_ff @(posedge clk) begin
    if (rst) begin
      isr_r <= 8'h00;
    end else if (ce) begin
      for (int l = 0; l < board_irq_pkg::LEVELS; l++) begin
        if (ackRead && reqPick[2:0] == 3'(l)) begin
          isr_r[l] <= 1'b1; // [R2] [R6]
        end else if (eoiWrite && isrPick[3] && isrPick[2:0] == 3'(l)) begin
          isr_r[l] <= 1'b0;
        end
      end
    end
  end

  // Serviced level becomes lowest after its end of interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      rotLow_r <= board_irq_pkg::LOW_RST;
    end else if (ce && eoiWrite && isrPick[3] && ctrl_r.mode == board_irq_pkg::MODE_ROTATE) begin
      rotLow_r <= isrPick[2:0]; // [R4]
    end
  end

  // Level driving the cascade select lines on acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      cascadeSel <= 3'h0;
    end else if (ce && ackRead) begin
      cascadeSel <= reqPick[2:0]; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus fail-safe timer and power-fail flag

  logic [31:0] stwClr;
  assign stwClr = (wrAcc && paddr == board_irq_pkg::STAT_OFS) ? pwdata : 32'h0;

  // Counts while an addressed bus command waits for its acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      tmoCnt_r <= '0;
    end else if (ce) begin
      if (!cmdActS || cmdAckS) begin
        tmoCnt_r <= '0;
      end else if (tmoCnt_r != board_irq_pkg::TMO_CNT_W'(FAILSAFE_CYCLES)) begin
        tmoCnt_r <= tmoCnt_r + 1'b1; // [R14]
      end
    end
  end

  // Sticky flags, set wins over a write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      tmoFlag_r <= 1'b0;
      pfFlag_r <= 1'b0;
      mainsLowD_r <= 1'b0;
    end else if (ce) begin
      mainsLowD_r <= mainsLowS;
      if (tmoCnt_r == board_irq_pkg::TMO_CNT_W'(FAILSAFE_CYCLES - 1) && cmdActS && !cmdAckS) begin
        tmoFlag_r <= 1'b1; // [R14]
      end else if (stwClr[board_irq_pkg::STAT_TMO_BIT]) begin
        tmoFlag_r <= 1'b0;
      end
      if (mainsLowS && !mainsLowD_r) begin
        pfFlag_r <= 1'b1; // [R16]
      end else if (stwClr[board_irq_pkg::STAT_PFAIL_BIT]) begin
        pfFlag_r <= 1'b0;
      end
    end
  end

  // RAM access block while memory protect is low
  always_ff @(posedge clk) begin
    if (rst) begin
      ramBlock <= 1'b0;
    end else if (ce) begin
      ramBlock <= !protS_n; // [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read data and handshake

  logic [31:0] rdMux;
  logic [7:0] vecOut;

  // Cascaded level takes the slave unit's vector
  assign vecOut = (reqPick[3] && casc_r[reqPick[2:0]]) ? slaveVecS : {vbase_r, reqPick[2:0]}; // [R11]

  always_comb begin
    rdMux = 32'h0;
    case (paddr)
      board_irq_pkg::CTRL_OFS: begin
        rdMux[board_irq_pkg::CTRL_MODE_LSB +: 2] = ctrl_r.mode;
        rdMux[board_irq_pkg::CTRL_LOW_LSB +: 3] = ctrl_r.lowest;
      end
      board_irq_pkg::MASK_OFS: rdMux[7:0] = mask_r;
      board_irq_pkg::PEND_OFS: begin
        rdMux[7:0] = levelReq; // [R23]
        rdMux[board_irq_pkg::PEND_ISR_LSB +: 8] = isr_r;
      end
      board_irq_pkg::POLL_OFS: begin
        rdMux[board_irq_pkg::POLL_VALID_BIT] = reqPick[3]; // [R6]
        rdMux[2:0] = reqPick[2:0]; // [R6]
      end
      board_irq_pkg::VECT_OFS: rdMux[7:0] = vecOut;
      board_irq_pkg::VBASE_OFS: rdMux[board_irq_pkg::VBASE_LSB +: 5] = vbase_r;
      board_irq_pkg::ROUTE0_OFS: rdMux = route_r[31:0];
      board_irq_pkg::ROUTE1_OFS: rdMux = route_r[63:32];
      board_irq_pkg::ROUTE2_OFS: rdMux = route_r[95:64];
      board_irq_pkg::STAT_OFS: begin
        rdMux[board_irq_pkg::STAT_TMO_BIT] = tmoFlag_r;
        rdMux[board_irq_pkg::STAT_PFAIL_BIT] = pfFlag_r;
        rdMux[board_irq_pkg::STAT_RAMBLK_BIT] = ramBlock;
      end
      board_irq_pkg::CASC_OFS: rdMux[7:0] = casc_r;
      default: rdMux = 32'h0;
    endcase
  end

  // One wait state: ready one cycle after access phase starts
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      pready <= acc;
      pslverr <= acc && !mapped;
      if (rdAcc) begin
        prdata <= mapped ? rdMux : 32'h0;
      end
    end
  end

endmodule : board_interrupt_priority_unit

`default_nettype wire

// *** core/board_irq_pkg.sv ***
// Package with register map, field layouts, reset values, timing and types for the priority interrupt unit
package board_irq_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h04;
  localparam logic [7:0] PEND_OFS = 8'h08;
  localparam logic [7:0] POLL_OFS = 8'h0c;
  localparam logic [7:0] VECT_OFS = 8'h10;
  localparam logic [7:0] EOI_OFS = 8'h14;
  localparam logic [7:0] VBASE_OFS = 8'h18;
  localparam logic [7:0] ROUTE0_OFS = 8'h1c;
  localparam logic [7:0] ROUTE1_OFS = 8'h20;
  localparam logic [7:0] ROUTE2_OFS = 8'h24;
  localparam logic [7:0] STAT_OFS = 8'h28;
  localparam logic [7:0] CASC_OFS = 8'h2c;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LOW_LSB = 4;
  localparam int PEND_ISR_LSB = 8;
  localparam int POLL_VALID_BIT = 7;
  localparam int STAT_TMO_BIT = 0;
  localparam int STAT_PFAIL_BIT = 1;
  localparam int STAT_RAMBLK_BIT = 2;
  localparam int VBASE_LSB = 3;

  // Sizes
  localparam int LEVELS = 8;
  localparam int SOURCES = 24;
  localparam int ROUTE_W = 4;
  localparam int SRC_PER_WORD = 8;

  // Source index of the internally generated requests
  localparam int SRC_TMO = 20;
  localparam int SRC_PFAIL = 21;

  // Route codes: 0..7 a level, 8 the nonmaskable line, others disconnected
  localparam logic [3:0] ROUTE_NMI = 4'h8;
  localparam logic [3:0] ROUTE_NONE = 4'hf;

  // Reset values
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [4:0] VBASE_RST = 5'h00;
  localparam logic [2:0] LOW_RST = 3'h7;
  localparam logic [7:0] CASC_RST = 8'h00;
  localparam logic [31:0] ROUTE_RST = 32'hffffffff;

  // Bus fail-safe timing
  localparam int CLK_HZ = 40000000;
  localparam int FAILSAFE_MS = 6;
  localparam int FAILSAFE_CYCLES_DEF = FAILSAFE_MS * (CLK_HZ / 1000);
  localparam int TMO_CNT_W = 20;

  // Priority modes
  typedef enum logic [1:0] {
    MODE_NESTED,
    MODE_ROTATE,
    MODE_SPECIFIC,
    MODE_POLLED
  } pri_mode_e;

  // Control register contents
  typedef struct packed {
    logic [2:0] lowest;
    pri_mode_e mode;
  } ctrl_s;

  // Grouped request sources of the board
  typedef struct packed {
    logic coproc;
    logic external;
    logic lineClock;
    logic [3:0] expansion;
    logic [1:0] timer;
    logic [1:0] serial;
    logic [2:0] parallel;
    logic [7:0] bus;
  } irq_src_s;

endpackage : board_irq_pkg

// *** testbench/board_irq_sva.sv ***
// Port checker for the priority interrupt unit
`timescale 1ns/10ps
`default_nettype none
module board_irq_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and outputs
  input wire logic memProtect_n,
  input wire logic cpuIrq,
  input wire logic cpuNmi,
  input wire logic [2:0] cascadeSel,
  input wire logic ramBlock
);
  logic take;
  logic bad;
  // Access taken at this edge, and unmapped decode
  assign take = psel && penable && !pready;
  assign bad = paddr > board_irq_pkg::CASC_OFS || paddr[1:0] != 2'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  answer_once_a:
    assert property (take |=> pready ##1 !pready)
    else $error("pready not one pulse");
  pready_cause_a:
    assert property (pready |-> $past(take))
    else $error("pready without access");
  err_pairs_a:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a:
    assert property (take && bad && !pwrite |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  mapped_ok_a:
    assert property (take && !bad |=> !pslverr)
    else $error("mapped access refused");
  rdata_hold_a:
    assert property (!(take && (!pwrite || bad)) |=> $stable(prdata))
    else $error("read data moved without read");
  cascade_cause_a:
    assert property ($changed(cascadeSel) && !$past(rst) |-> $past(take && !pwrite &&
      (paddr == board_irq_pkg::VECT_OFS || paddr == board_irq_pkg::POLL_OFS)))
    else $error("cascade select moved without acknowledge");
  block_on_a:
    assert property ((ce && !memProtect_n) [*4] |=> ramBlock)
    else $error("RAM not blocked");
  block_off_a:
    assert property ((ce && memProtect_n) [*4] |=> !ramBlock)
    else $error("RAM blocked while unprotected");
  reset_quiet_a:
    assert property ($past(rst && ce) |-> !cpuIrq && !cpuNmi && !ramBlock && !pready)
    else $error("outputs active after reset");
endmodule : board_irq_sva
bind board_interrupt_priority_unit board_irq_sva sva_u (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .memProtect_n(memProtect_n), .cpuIrq(cpuIrq), .cpuNmi(cpuNmi), .cascadeSel(cascadeSel), .ramBlock(ramBlock));
`default_nettype wire

// *** testbench/cpu_host_model.sv ***
// Host processor model issuing APB transfers to the unit
`timescale 1ns/10ps
`default_nettype none
module cpu_host_model (
  // Clock
  input wire logic clk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  ////////////////////////////////////////////////////////////////
  // One transfer, entered just after an edge; a lost answer gives unknown data
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    q = (n < 20) ? prdata : 'x;
    e = (n < 20) ? pslverr : 1'bx;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk);
  endtask : xfer
endmodule : cpu_host_model
`default_nettype wire

// *** testbench/test_board_interrupt_priority_unit.sv ***
// Self-checking bench for the priority interrupt unit
`timescale 1ns/10ps
`default_nettype none
module test_board_interrupt_priority_unit;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr;
  logic busCmdActive, busCmdAck, mainsLowWarning, memProtect_n, cpuIrq, cpuNmi, ramBlock;
  logic [7:0] paddr, slaveVector, p;
  logic [31:0] pwdata, prdata, r, q;
  logic [2:0] cascadeSel, low;
  logic e;
  board_irq_pkg::irq_src_s irqSrc;
  int bad_count, check_count, seed;
  cpu_host_model host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  board_interrupt_priority_unit #(.FAILSAFE_CYCLES(20)) dut_u (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irqSrc(irqSrc), .busCmdActive(busCmdActive), .busCmdAck(busCmdAck),
    .mainsLowWarning(mainsLowWarning), .memProtect_n(memProtect_n), .slaveVector(slaveVector),
    .cpuIrq(cpuIrq), .cpuNmi(cpuNmi), .cascadeSel(cascadeSel), .ramBlock(ramBlock));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] x);
    check_count++;
    if (seen !== x) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, x);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    host_u.xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask : rdc
  // Drive the source pins and let them pass the synchronisers
  task automatic src(input logic [21:0] v);
    irqSrc <= board_irq_pkg::irq_src_s'(v);
    repeat (4) @(posedge clk);
  endtask : src
  // Winning level: search upward from the level after the lowest
  function automatic logic [2:0] pick(input logic [7:0] pend, input logic [2:0] lo);
    logic [2:0] l;
    pick = lo;
    for (int i = 1; i <= 8; i++) begin
      l = lo + i[2:0];
      if (pend[l]) return l;
    end
  endfunction : pick
  task automatic summarize();
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end
  // Main sequence
  initial begin
    seed = 32'h598fe268;
    {rst, ce, memProtect_n} = 3'h7;
    {busCmdActive, busCmdAck, mainsLowWarning} = 3'h0;
    slaveVector = 8'h00;
    irqSrc = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(board_irq_pkg::CTRL_OFS, 32'h70);
    rdc(board_irq_pkg::MASK_OFS, 32'hff);
    rdc(board_irq_pkg::ROUTE0_OFS, board_irq_pkg::ROUTE_RST);
    rdc(8'h30, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(board_irq_pkg::ROUTE0_OFS, 32'h76543210);
    wr(board_irq_pkg::MASK_OFS, 32'h0);
    wr(board_irq_pkg::VBASE_OFS, 32'h50);
    // Random requests in nested and specific modes, mode changed on the fly
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      p = (r[7:0] == 8'h00) ? 8'h01 : r[7:0];
      low = i[0] ? r[10:8] : 3'h7;
      wr(board_irq_pkg::CTRL_OFS, {25'h0, low, 2'h0, i[0], 1'b0});
      src({14'h0, p});
      chk({31'h0, cpuIrq}, 32'h1);
      rdc(board_irq_pkg::PEND_OFS, {24'h0, p});
      rdc(board_irq_pkg::VECT_OFS, {24'h0, 5'h0a, pick(p, low)});
      chk({31'h0, cpuIrq}, 32'h0);
      wr(board_irq_pkg::EOI_OFS, 32'h0);
    end
    // Masked level stays pending but loses arbitration
    wr(board_irq_pkg::CTRL_OFS, 32'h70);
    src(22'h28);
    wr(board_irq_pkg::MASK_OFS, 32'h08);
    rdc(board_irq_pkg::PEND_OFS, 32'h28);
    rdc(board_irq_pkg::VECT_OFS, 32'h55);
    wr(board_irq_pkg::EOI_OFS, 32'h0);
    wr(board_irq_pkg::MASK_OFS, 32'hff);
    chk({31'h0, cpuIrq}, 32'h0);
    // Polled status
    wr(board_irq_pkg::MASK_OFS, 32'h0);
    wr(board_irq_pkg::CTRL_OFS, 32'h73);
    chk({31'h0, cpuIrq}, 32'h0);
    rdc(board_irq_pkg::POLL_OFS, 32'h83);
    wr(board_irq_pkg::EOI_OFS, 32'h0);
    // Rotation: serviced level drops to the bottom
    wr(board_irq_pkg::CTRL_OFS, 32'h71);
    for (int i = 0; i < 3; i++) begin
      rdc(board_irq_pkg::VECT_OFS, i[0] ? 32'h55 : 32'h53);
      wr(board_irq_pkg::EOI_OFS, 32'h0);
    end
    // Cascaded slave supplies the vector
    wr(board_irq_pkg::CTRL_OFS, 32'h70);
    wr(board_irq_pkg::CASC_OFS, 32'h20);
    slaveVector <= 8'hc6;
    src(22'h20);
    rdc(board_irq_pkg::VECT_OFS, 32'hc6);
    chk({29'h0, cascadeSel}, 32'h5);
    wr(board_irq_pkg::EOI_OFS, 32'h0);
    // Source 8 to the nonmaskable line, source 20 to level 4
    wr(board_irq_pkg::ROUTE1_OFS, 32'hfffffff8);
    wr(board_irq_pkg::ROUTE2_OFS, 32'hfff4ffff);
    src(22'h100);
    chk({30'h0, cpuNmi, cpuIrq}, 32'h2);
    src(22'h0);
    chk({31'h0, cpuNmi}, 32'h0);
    // Bus fail-safe timeout and power-fail flags
    busCmdActive <= 1'b1;
    repeat (10) @(posedge clk);
    rdc(board_irq_pkg::STAT_OFS, 32'h0);
    repeat (16) @(posedge clk);
    rdc(board_irq_pkg::STAT_OFS, 32'h1);
    rdc(board_irq_pkg::PEND_OFS, 32'h10);
    busCmdActive <= 1'b0;
    mainsLowWarning <= 1'b1;
    wr(board_irq_pkg::STAT_OFS, 32'h1);
    rdc(board_irq_pkg::STAT_OFS, 32'h2);
    wr(board_irq_pkg::STAT_OFS, 32'h2);
    rdc(board_irq_pkg::STAT_OFS, 32'h0);
    // Clock enable low freezes the synchronisers and outputs
    ce <= 1'b0;
    memProtect_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, ramBlock}, 32'h0);
    ce <= 1'b1;
    // Memory protect
    memProtect_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, ramBlock}, 32'h1);
    rdc(board_irq_pkg::STAT_OFS, 32'h4);
    memProtect_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, ramBlock}, 32'h0);
    summarize();
  end
endmodule : test_board_interrupt_priority_unit
`default_nettype wire
